// ===== verilog/irq_init_pkg.sv
package irq_init_pkg;
  // controller count and widths
  localparam int NUM_CTRL   = 2;
  localparam int IRQ_W      = 8;
  localparam int DATA_W     = 8;
  localparam int ADDR_W     = 16;
  localparam int VEC_BASE_W = 5;
  localparam int LEVEL_W    = 3;

  // host i/o port addresses
  localparam logic [ADDR_W-1:0] PRIMARY_BASE   = 16'h0020;
  localparam logic [ADDR_W-1:0] PRIMARY_DATA   = 16'h0021;
  localparam logic [ADDR_W-1:0] SECONDARY_BASE = 16'h00a0;
  localparam logic [ADDR_W-1:0] SECONDARY_DATA = 16'h00a1;

  // init_word_one field positions, and the low bit of the vector word
  localparam int INIT_SEL_BIT = 4;
  localparam int MODE_REQ_BIT = 0;
  localparam int LEVEL_BIT    = 3;
  localparam int VEC_LSB      = 3;

  // values loaded when initialization starts
  localparam logic [LEVEL_W-1:0] LOWEST_PRIO_INIT = 3'h7;
  localparam logic [LEVEL_W-1:0] SLAVE_ADDR_INIT  = 3'h7;
  localparam logic [IRQ_W-1:0]   MASK_CLEAR       = 8'h00;
  localparam logic [DATA_W-1:0]  MODE_CLEAR       = 8'h00;
  localparam logic [DATA_W-1:0]  WORD_CLEAR       = 8'h00;

  // init sequence state, one-hot
  typedef enum logic [4:0] {
    SEQ_IDLE = 5'h01,
    SEQ_VEC  = 5'h02,
    SEQ_CASC = 5'h04,
    SEQ_MODE = 5'h08,
    SEQ_RDY  = 5'h10
  } seq_state_t;

  // host i/o write
  typedef struct packed {
    logic              strobe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } io_wr_t;

  // interrupt acknowledge request
  typedef struct packed {
    logic               strobe;
    logic               ctrl;
    logic [LEVEL_W-1:0] level;
  } ack_req_t;

  // per-controller programmed state
  typedef struct packed {
    logic                  init_done;
    logic                  level_mode;
    logic                  mode_required;
    logic [VEC_BASE_W-1:0] vec_base;
    logic [DATA_W-1:0]     cascade;
    logic [DATA_W-1:0]     mode;
    logic [IRQ_W-1:0]      mask;
    logic [LEVEL_W-1:0]    lowest_prio;
    logic [LEVEL_W-1:0]    slave_addr;
    logic                  special_mask;
    logic                  read_irr;
  } ctrl_status_t;

  // operation-command word forwarded downstream
  typedef struct packed {
    logic              valid;
    logic              ctrl;
    logic [DATA_W-1:0] data;
  } op_word_t;

  // acknowledge answer
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] vector;
  } ack_out_t;

  // vector = stored base above the serviced input number
  function automatic logic [DATA_W-1:0] vector_of(input logic [VEC_BASE_W-1:0] base,
                                                  input logic [LEVEL_W-1:0] level);
    return {base, level};
  endfunction

  // decode one controller port: odd selects base+1
  function automatic logic port_hit(input io_wr_t wr, input int c, input logic odd);
    logic [ADDR_W-1:0] a;
    if (c == 0) begin
      a = odd ? PRIMARY_DATA : PRIMARY_BASE;
    end else begin
      a = odd ? SECONDARY_DATA : SECONDARY_BASE;
    end
    return wr.strobe && (wr.addr == a);
  endfunction
endpackage

// ===== verilog/irq_request_sense.sv
`timescale 1ns/1ps
module irq_request_sense #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             init_start,
  input  wire logic             level_mode,
  input  wire logic [WIDTH-1:0] req,
  input  wire logic [WIDTH-1:0] mask,
  input  wire logic [WIDTH-1:0] clear,
  output logic      [WIDTH-1:0] pending_reg
);
  ////////////////////////////////////////////////////////////////////////////
  // state of the sense stage
  typedef struct packed {
    logic [WIDTH-1:0] prev;    // request level seen last cycle
    logic [WIDTH-1:0] latched; // captured edges awaiting service
    logic [WIDTH-1:0] pend;    // unmasked pending view
  } sense_state_t;

  sense_state_t state_reg;   // registered state
  sense_state_t state_next;  // next state

  ////////////////////////////////////////////////////////////////////////////
  // edge or level capture
  always_comb begin
    state_next = state_reg;
    if (init_start) begin
      // prev forced high so a line must fall and rise again
      state_next.prev    = '1;
      state_next.latched = '0;
    end else begin
      state_next.prev    = req;
      // a new edge outranks an acknowledge of the same input in one cycle
      state_next.latched = (state_reg.latched & ~clear) | (req & ~state_reg.prev);
    end
    // level mode follows the line, edge mode the latch; nothing right after init
    if (init_start) begin
      state_next.pend = '0;
    end else if (level_mode) begin
      state_next.pend = req & ~mask;
    end else begin
      state_next.pend = state_next.latched & ~mask;
    end
  end

  // register, frozen while clk_en is low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{prev: '1, latched: '0, pend: '0};
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign pending_reg = state_reg.pend;
endmodule

// ===== verilog/cascaded_irq_init_sequencer.sv
`timescale 1ns/1ps
module cascaded_irq_init_sequencer
  import irq_init_pkg::*;
#(
  parameter logic LEVEL_FIXED_HIGH = 1'b0 // variant that ignores the sense bit
) (
  input  wire logic                                       clock,
  input  wire logic                                       rst_n,
  input  wire logic                                       clk_en,
  input  wire irq_init_pkg::io_wr_t                       io_wr,
  input  wire irq_init_pkg::ack_req_t                     ack_req,
  input  wire logic [irq_init_pkg::NUM_CTRL-1:0]
                    [irq_init_pkg::IRQ_W-1:0]             irq_req,
  output irq_init_pkg::ctrl_status_t [irq_init_pkg::NUM_CTRL-1:0] status_reg,
  output irq_init_pkg::op_word_t                          op_word_reg,
  output irq_init_pkg::ack_out_t                          ack_reg,
  output logic [irq_init_pkg::NUM_CTRL-1:0]
               [irq_init_pkg::IRQ_W-1:0]                  pending_reg
);
  import irq_init_pkg::*;

  // both controllers share one host write port and one acknowledge port;
  // each write touches at most one controller, since the four ports differ
  // the sequencer programs state, answers acknowledges and senses requests; priority resolution and the command
  // words themselves live downstream and see op_word_reg
  // every register here is frozen as a whole while clk_en is low, so a
  // host write or acknowledge seen in a frozen cycle is simply not taken
  // software must space its writes so that each lands in an enabled cycle

  ////////////////////////////////////////////////////////////////////////////
  // state of both controllers
  // the sequence position and the programmed values travel together
  typedef struct packed {
    seq_state_t   seq; // where the init sequence stands
    ctrl_status_t st;  // programmed values
  } ctrl_state_t;

  typedef struct packed {
    ctrl_state_t [NUM_CTRL-1:0] ctl; // per controller
    op_word_t                   op;  // forwarded command word
    ack_out_t                   ack; // acknowledge vector
  } top_state_t;

  top_state_t                           state_reg;  // registered state
  top_state_t                           state_next; // next state
  logic [NUM_CTRL-1:0]                  init_start; // init word seen this cycle
  logic [NUM_CTRL-1:0][IRQ_W-1:0]       ack_clear;  // pending bit to drop

  ////////////////////////////////////////////////////////////////////////////
  // reset value of one controller
  function automatic ctrl_state_t ctrl_reset();
    ctrl_state_t s;
    s                = '0;
    s.seq            = SEQ_IDLE;
    s.st.mask        = MASK_CLEAR;
    s.st.lowest_prio = LOWEST_PRIO_INIT;
    s.st.slave_addr  = SLAVE_ADDR_INIT;
    s.st.read_irr    = 1'b1;
    s.st.level_mode  = LEVEL_FIXED_HIGH;
    return s;
  endfunction

  // reset image as a constant, so the asynchronous branch loads no logic
  localparam ctrl_state_t CTRL_RST = ctrl_reset();

  ////////////////////////////////////////////////////////////////////////////
  // host write decode and init sequencing
  // an init word wins over anything the same controller had in flight, so
  // software can recover from a half-finished sequence by starting again
  // pulse outputs fall back to zero each cycle unless a write or acknowledge renews them
  always_comb begin
    state_next           = state_reg;
    state_next.op.valid  = 1'b0;
    state_next.ack.valid = 1'b0;
    init_start           = '0;
    ack_clear            = '0;
    for (int c = 0; c < NUM_CTRL; c++) begin
      // only the documented host i/o ports decode
      if (port_hit(io_wr, c, 1'b0) && io_wr.data[INIT_SEL_BIT]) begin
        // init word, accepted in any state
        // defaults load at once; the old vector and cascade words stay
        // until the new sequence rewrites them
        init_start[c]                        = 1'b1;
        state_next.ctl[c].seq                = SEQ_VEC;
        state_next.ctl[c].st.init_done       = 1'b0;
        state_next.ctl[c].st.mask            = MASK_CLEAR;
        state_next.ctl[c].st.lowest_prio     = LOWEST_PRIO_INIT;
        state_next.ctl[c].st.slave_addr      = SLAVE_ADDR_INIT;
        state_next.ctl[c].st.special_mask    = 1'b0;
        state_next.ctl[c].st.read_irr        = 1'b1;
        // bits 7..5, 2 and 1 are not decoded
        state_next.ctl[c].st.mode_required   = io_wr.data[MODE_REQ_BIT];
        if (LEVEL_FIXED_HIGH) begin
          state_next.ctl[c].st.level_mode    = 1'b1;
        end else begin
          state_next.ctl[c].st.level_mode    = io_wr.data[LEVEL_BIT];
        end
        // without a mode word its functions fall to zero
        if (!io_wr.data[MODE_REQ_BIT]) begin
          state_next.ctl[c].st.mode          = MODE_CLEAR;
        end
      end else if (port_hit(io_wr, c, 1'b0)) begin
        // base write with bit 4 low: command word once ready
        // before that it is dropped silently, as there is nothing to
        // command until the sequence has finished
        if (state_reg.ctl[c].seq == SEQ_RDY) begin
          state_next.op.valid = 1'b1;
          state_next.op.ctrl  = c[0];
          state_next.op.data  = io_wr.data;
        end
      end else if (port_hit(io_wr, c, 1'b1)) begin
        // base+1 follows the sequence until it completes
        case (state_reg.ctl[c].seq)
          SEQ_VEC: begin
            // only the top five bits count; the low three are filled in
            // with the serviced input number at acknowledge time
            state_next.ctl[c].st.vec_base = io_wr.data[DATA_W-1:VEC_LSB];
            state_next.ctl[c].seq         = SEQ_CASC;
          end
          SEQ_CASC: begin
            // the cascade word is stored as written; its meaning differs
            // between primary and secondary and is left to the cascade logic
            state_next.ctl[c].st.cascade = io_wr.data;
            if (state_reg.ctl[c].st.mode_required) begin
              state_next.ctl[c].seq = SEQ_MODE;
            end else begin
              state_next.ctl[c].seq          = SEQ_RDY;
              state_next.ctl[c].st.init_done = 1'b1;
            end
          end
          SEQ_MODE: begin
            state_next.ctl[c].st.mode      = io_wr.data;
            state_next.ctl[c].seq          = SEQ_RDY;
            state_next.ctl[c].st.init_done = 1'b1;
          end
          SEQ_RDY: begin
            // complete: base+1 now writes the mask
            state_next.ctl[c].st.mask = io_wr.data;
          end
          default: begin
            // idle: nothing programmed yet, write ignored
            state_next.ctl[c].seq = state_reg.ctl[c].seq;
          end
        endcase
      end
    end
    // acknowledge: base above the input number
    // the base is the one stored before this edge; a vector word written in
    // the same cycle only affects later acknowledges
    // the serviced input's edge latch is dropped in the sense stage
    if (ack_req.strobe) begin
      state_next.ack.valid  = 1'b1;
      state_next.ack.vector = vector_of(state_reg.ctl[ack_req.ctrl].st.vec_base,
                                        ack_req.level);
      ack_clear[ack_req.ctrl][ack_req.level] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register, frozen while clk_en is low
  // reset leaves both controllers idle: base+1 writes are dropped and no
  // command word passes until a full sequence has been written
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{ctl: {NUM_CTRL{CTRL_RST}}, op: '0, ack: '0};
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request sensing, one stage per controller
  // the stage sees the sense mode and mask already registered here, so a
  // change takes effect one cycle after the write that makes it
  // init_start reaches it in the same cycle so edge history restarts at once
  for (genvar g = 0; g < NUM_CTRL; g++) begin : g_sense
    irq_request_sense #(
      .WIDTH (IRQ_W)
    ) u_sense (
      .clock       (clock),
      .rst_n       (rst_n),
      .clk_en      (clk_en),
      .init_start  (init_start[g]),
      .level_mode  (state_reg.ctl[g].st.level_mode),
      .req         (irq_req[g]),
      .mask        (state_reg.ctl[g].st.mask),
      .clear       (ack_clear[g]),
      .pending_reg (pending_reg[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  // no gating on the way out: every port bit is a flip-flop output
  always_comb begin
    for (int c = 0; c < NUM_CTRL; c++) begin
      status_reg[c] = state_reg.ctl[c].st;
    end
  end
  assign op_word_reg = state_reg.op;
  assign ack_reg     = state_reg.ack;
endmodule

// ===== tb/cirq_chk.sv
`timescale 1ns/1ps
module cirq_chk
  import irq_init_pkg::*;
#(
  parameter logic LEVEL_FIXED_HIGH = 1'b0
) (
  input wire logic                           clock,
  input wire logic                           rst_n,
  input wire logic                           clk_en,
  input wire io_wr_t                         io_wr,
  input wire ack_req_t                       ack_req,
  input wire logic [NUM_CTRL-1:0][IRQ_W-1:0] irq_req,
  input wire ctrl_status_t [NUM_CTRL-1:0]    status_reg,
  input wire op_word_t                       op_word_reg,
  input wire ack_out_t                       ack_reg,
  input wire logic [NUM_CTRL-1:0][IRQ_W-1:0] pending_reg
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic wr0;  // enabled write to any port
  logic init0; // primary init word
  logic cmd0;  // primary command word after setup
  logic data0; // primary base+1 write
  assign wr0   = clk_en && io_wr.strobe;
  assign init0 = wr0 && io_wr.addr == PRIMARY_BASE && io_wr.data[4];
  assign cmd0  = wr0 && io_wr.addr == PRIMARY_BASE && !io_wr.data[4] && status_reg[0].init_done;
  assign data0 = wr0 && io_wr.addr == PRIMARY_DATA;
  property p_init_mask;
    init0 |=> status_reg[0].mask == MASK_CLEAR && !status_reg[0].init_done;
  endproperty
  a_init_mask: assert property (p_init_mask) else $error("mask not cleared by init");
  property p_init_prio;
    init0 |=> status_reg[0].lowest_prio == 3'h7 && status_reg[0].slave_addr == 3'h7;
  endproperty
  a_init_prio: assert property (p_init_prio) else $error("priority defaults wrong");
  property p_init_read;
    init0 |=> !status_reg[0].special_mask && status_reg[0].read_irr;
  endproperty
  a_init_read: assert property (p_init_read) else $error("status read defaults wrong");
  property p_init_edge;
    init0 && !io_wr.data[3] && !LEVEL_FIXED_HIGH |=> pending_reg[0] == 8'h00;
  endproperty
  a_init_edge: assert property (p_init_edge) else $error("pending kept over init");
  property p_sense;
    init0 |=> status_reg[0].level_mode == (LEVEL_FIXED_HIGH | $past(io_wr.data[3]));
  endproperty
  a_sense: assert property (p_sense) else $error("sense mode wrong");
  property p_ack;
    clk_en && ack_req.strobe |=> ack_reg.valid
      && ack_reg.vector == {$past(status_reg[ack_req.ctrl].vec_base), $past(ack_req.level)};
  endproperty
  a_ack: assert property (p_ack) else $error("ack vector wrong");
  property p_cmd;
    cmd0 |=> op_word_reg.valid && op_word_reg.data == $past(io_wr.data);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command word lost");
  property p_no_cmd;
    $past(clk_en) && op_word_reg.valid |-> $past(io_wr.strobe && !io_wr.data[4]);
  endproperty
  a_no_cmd: assert property (p_no_cmd) else $error("command pulse without cause");
  property p_mask_hold;
    data0 && !status_reg[0].init_done |=> status_reg[0].mask == $past(status_reg[0].mask);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask written during init");
  property p_freeze;
    !clk_en |=> status_reg == $past(status_reg) && pending_reg == $past(pending_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");
  c_freeze: cover property (!clk_en);
  c_init: cover property (init0);
  c_cmd: cover property (cmd0);
  c_ack: cover property (ack_req.strobe);
endmodule
bind cascaded_irq_init_sequencer cirq_chk #(.LEVEL_FIXED_HIGH(LEVEL_FIXED_HIGH)) chk_u (
  .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .io_wr(io_wr), .ack_req(ack_req),
  .irq_req(irq_req), .status_reg(status_reg), .op_word_reg(op_word_reg),
  .ack_reg(ack_reg), .pending_reg(pending_reg));

// ===== tb/irq_host_model.sv
`timescale 1ns/1ps
module irq_host_model
  import irq_init_pkg::*;
(
  input wire logic clock,
  output io_wr_t   io_wr,
  output ack_req_t ack_req
);
  initial begin
    io_wr = '0;
    ack_req = '0;
  end
  // one-cycle write pulse; released bus shows inverted junk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    #1;
    io_wr = '{1'b1, a, d};
    @(posedge clock);
    #1;
    io_wr = '{1'b0, ~a, ~d};
  endtask
  // one-cycle acknowledge pulse
  task automatic ack(input logic c, input logic [2:0] l);
    @(posedge clock);
    #1;
    ack_req = '{1'b1, c, l};
    @(posedge clock);
    #1;
    ack_req = '{1'b0, ~c, ~l};
  endtask
  // full setup sequence as system software does it
  task automatic init(input logic c, input logic [7:0] vb, input logic lvl, input logic req);
    logic [ADDR_W-1:0] b;
    b = c ? SECONDARY_BASE : PRIMARY_BASE;
    wr(b, {3'b000, 1'b1, lvl, 1'b0, 1'b0, req});
    wr(b + 16'h0001, vb);
    wr(b + 16'h0001, c ? 8'h02 : 8'h04);
    if (req) begin
      wr(b + 16'h0001, 8'h01);
    end
  endtask
endmodule

// ===== tb/cascaded_irq_init_sequencer_tb_top.sv
`timescale 1ns/1ps
module cascaded_irq_init_sequencer_tb_top;
  import irq_init_pkg::*;
  logic                           clock;
  logic                           rst_n;
  logic                           clk_en;
  io_wr_t                         io_wr;
  ack_req_t                       ack_req;
  logic [NUM_CTRL-1:0][IRQ_W-1:0] irq_req;
  logic [NUM_CTRL-1:0][IRQ_W-1:0] pending_reg;
  ctrl_status_t [NUM_CTRL-1:0]    status_reg;
  op_word_t                       op_word_reg;
  ack_out_t                       ack_reg;
  int                             failures;
  int                             n_tests;
  int                             seed;
  int                             i;
  int                             c;
  int                             l;
  logic [7:0]                     vb;
  logic                           ct;
  logic [7:0]                     ack_q[$]; // expected vectors
  logic [8:0]                     op_q[$];  // expected {ctrl, command}
  cascaded_irq_init_sequencer dut_u (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .io_wr(io_wr), .ack_req(ack_req), .irq_req(irq_req), .status_reg(status_reg),
    .op_word_reg(op_word_reg), .ack_reg(ack_reg), .pending_reg(pending_reg));
  irq_host_model host_u (.clock(clock), .io_wr(io_wr), .ack_req(ack_req));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  // result watcher: every pulse takes the oldest note
  always @(posedge clock) begin
    #2;
    if (ack_reg.valid === 1'b1) begin
      if (ack_q.size() == 0) check("ack extra", 1, 0);
      else check("ack vector", ack_reg.vector, ack_q.pop_front());
    end
    if (op_word_reg.valid === 1'b1) begin
      if (op_q.size() == 0) check("op extra", 1, 0);
      else check("op word", {op_word_reg.ctrl, op_word_reg.data}, op_q.pop_front());
    end
  end
  initial begin
    #400000;
    check("timeout", 0, 1);
    stop_test();
  end
  initial begin
    seed = 77;
    clk_en = 1;
    irq_req = '0;
    rst_n = 0;
    repeat (4) @(posedge clock);
    #1 rst_n = 1;
    check("rst mask", status_reg[0].mask, 0);
    check("rst prio", {status_reg[1].lowest_prio, status_reg[1].slave_addr}, 6'o77);
    // commands and base+1 writes before setup are dropped
    host_u.wr(PRIMARY_BASE, 8'h0a);
    host_u.wr(PRIMARY_DATA, 8'h55);
    check("pre mask", status_reg[0].mask, 0);
    $display("test refuse done");
    for (c = 0; c < 2; c++) begin
      for (l = 0; l < 2; l++) begin
        vb = c ? 8'h70 : 8'h04;
        host_u.init(c[0], vb, l[0], 1'b1);
        check("done", status_reg[c].init_done, 1);
        check("vec", status_reg[c].vec_base, vb[7:3]);
        check("casc", status_reg[c].cascade, c ? 8'h02 : 8'h04);
        check("mode", status_reg[c].mode, 8'h01);
        check("sense", status_reg[c].level_mode, l);
      end
    end
    for (i = 0; i < 8; i++) begin
      ct = 1'($random(seed));
      ack_q.push_back({ct ? 5'h0e : 5'h00, i[2:0]});
      host_u.ack(ct, i[2:0]);
    end
    op_q.push_back(9'h020);
    host_u.wr(PRIMARY_BASE, 8'h20);
    op_q.push_back(9'h10b);
    host_u.wr(SECONDARY_BASE, 8'h0b);
    $display("test setup ack command done");
    irq_req[1] = 8'($random(seed));
    repeat (2) @(posedge clock);
    #1;
    check("level pend", pending_reg[1], irq_req[1]);
    host_u.wr(PRIMARY_DATA, 8'hff);
    check("mask wr", status_reg[0].mask, 8'hff);
    irq_req[0][5] = 1;
    host_u.init(0, 8'h77, 1'b0, 1'b1);
    check("re mask", status_reg[0].mask, 0);
    check("re vec", status_reg[0].vec_base, 5'h0e);
    repeat (3) @(posedge clock);
    #1;
    check("stale edge", pending_reg[0], 0);
    irq_req[0][5] = 0;
    repeat (2) @(posedge clock);
    #1;
    irq_req[0][5] = 1;
    for (i = 0; i < 6 && pending_reg[0][5] !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    check("fresh edge", pending_reg[0], 8'h20);
    ack_q.push_back({5'h0e, 3'd5});
    host_u.ack(1'b0, 3'd5);
    check("ack clr", pending_reg[0], 0);
    $display("test edge done");
    host_u.init(1, 8'h70, 1'b0, 1'b0);
    check("no mode done", status_reg[1].init_done, 1);
    check("no mode", status_reg[1].mode, 0);
    host_u.wr(PRIMARY_BASE, 8'hf5);
    host_u.wr(PRIMARY_DATA, 8'h08);
    host_u.wr(PRIMARY_DATA, 8'h04);
    host_u.wr(PRIMARY_DATA, 8'h01);
    check("junk bits", {status_reg[0].init_done, status_reg[0].vec_base}, 6'h21);
    host_u.wr(PRIMARY_BASE, 8'h11);
    host_u.wr(PRIMARY_DATA, 8'h08);
    check("mid init", status_reg[0].init_done, 0);
    host_u.init(0, 8'h70, 1'b0, 1'b1);
    check("restart", {status_reg[0].init_done, status_reg[0].vec_base}, 6'h2e);
    clk_en = 0;
    host_u.wr(PRIMARY_DATA, 8'h3c);
    check("frozen", status_reg[0].mask, 0);
    clk_en = 1;
    host_u.wr(PRIMARY_DATA, 8'h3c);
    check("thawed", status_reg[0].mask, 8'h3c);
    $display("test restart done");
    for (i = 0; i < 20 && (ack_q.size() + op_q.size()) != 0; i++) @(posedge clock);
    check("drain", ack_q.size() + op_q.size(), 0);
    stop_test();
  end
endmodule
